// [rtl/mci_pkg.sv]
// Constants and shared types for the modem control interface
//
// What this block does
// - Start sending only while send request, clear, set ready, terminal ready on.
// - Transmit data idles at mark between characters and when not sending.
// - Raising send request puts modem in transmit mode and sets direction.
// - Dropping send request ends transmission; modem finishes and stops transmitter.
// - While set ready is off, ignore clear, line detect and secondary tone; ring and transmit timing still act.
// - Received data is valid only while line signal detect is on.
// - Secondary send request asks modem for a reverse channel tone.
// - New-sync output is held permanently deasserted.
// - Transmit data changes only on off-to-on edges of transmit timing.
// - Sample receive data on on-to-off edge of receive timing, the bit centre.
package mci_pkg;
	localparam int ADDR_W = 4;
	localparam logic [3:0] OFF_CTRL = 4'h0;
	localparam logic [3:0] OFF_STAT = 4'h4;
	localparam logic [3:0] OFF_TXD = 4'h8;
	localparam logic [3:0] OFF_RXD = 4'hc;
	localparam int CTRL_SEND_REQ = 0;
	localparam int CTRL_TERM_RDY = 1;
	localparam int CTRL_SEC_REQ = 2;
	localparam int ST_CLEAR = 0;
	localparam int ST_SET_RDY = 1;
	localparam int ST_LINE_DET = 2;
	localparam int ST_SEC_TONE = 3;
	localparam int ST_RING = 4;
	localparam int ST_TX_BUSY = 5;
	localparam int ST_TX_FULL = 6;
	localparam int ST_RX_VALID = 7;
	localparam int ST_RX_OVR = 8;
	localparam logic [2:0] CTRL_RESET = 3'h0;
	localparam int SYNC_STAGES = 2;
	typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} mci_tx_e;
	typedef enum logic [1:0] {RX_IDLE, RX_DATA, RX_STOP} mci_rx_e;
endpackage

// [rtl/mci_sync.sv]
// Two-flop synchroniser bank for modem inputs
`timescale 1ns/1ps
`default_nettype none
module mci_sync #(
	parameter int WIDTH = 7
) (
	input wire logic i_mclk,
	input wire logic i_rstn,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;
	// Reset to zero: every status input reads as off until sampled
	always_ff @(posedge i_mclk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			meta_q <= '0;
			sync_q <= '0;
		end
		else
		begin
			meta_q <= i_async;
			sync_q <= meta_q;
		end
	end
	assign o_sync = sync_q;
endmodule // mci_sync
`default_nettype wire

// [rtl/mci_top.sv]
// Modem control interface: handshake, status and element-timed data
`timescale 1ns/1ps
`default_nettype none
module mci_top #(
	parameter int CHAR_W = 8
) (
	input wire logic i_mclk,
	input wire logic i_rstn,
	input wire logic [3:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	output logic o_tx_data_line,
	input wire logic i_rx_data_line,
	output logic o_send_request,
	input wire logic i_send_clear,
	input wire logic i_set_ready,
	output logic o_terminal_ready,
	input wire logic i_line_signal_detect,
	output logic o_secondary_send_request,
	input wire logic i_secondary_tone_detect,
	output logic o_new_sync,
	input wire logic i_modem_tx_element_timing,
	input wire logic i_modem_rx_element_timing,
	input wire logic i_ring
);
	localparam int CW = $clog2(CHAR_W + 1);
	////////////////////////////////////////////////////////////////////////
	// Input synchronisers
	logic [6:0] raw;
	logic [6:0] syn;
	assign raw = {i_ring, i_modem_rx_element_timing, i_modem_tx_element_timing,
		i_secondary_tone_detect, i_line_signal_detect, i_set_ready, i_send_clear};
	mci_sync #(.WIDTH(7)) u_sync (
		.i_mclk(i_mclk),
		.i_rstn(i_rstn),
		.i_async(raw),
		.o_sync(syn)
	);
	logic rxd_s;
	logic rxd_meta_q;
	logic rxd_sync_q;
	// Receive data resets to mark, so it has its own pair
	always_ff @(posedge i_mclk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			rxd_meta_q <= 1'b1;
			rxd_sync_q <= 1'b1;
		end
		else
		begin
			rxd_meta_q <= i_rx_data_line;
			rxd_sync_q <= rxd_meta_q;
		end
	end
	assign rxd_s = rxd_sync_q;
	logic clr_s, dsr_s, det_s, sec_s, txc_s, rxc_s, ring_s;
	assign {ring_s, rxc_s, txc_s, sec_s, det_s, dsr_s, clr_s} = syn;
	// Clear, line detect and secondary tone are qualified by set ready
	logic clr_v, det_v, sec_v;
	assign clr_v = clr_s & dsr_s;
	assign det_v = det_s & dsr_s;
	assign sec_v = sec_s & dsr_s;
	////////////////////////////////////////////////////////////////////////
	// Edge detection on element timing
	logic txc_q, rxc_q;
	always_ff @(posedge i_mclk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			txc_q <= 1'b0;
			rxc_q <= 1'b0;
		end
		else
		begin
			txc_q <= txc_s;
			rxc_q <= rxc_s;
		end
	end
	logic txc_rise, rxc_fall;
	assign txc_rise = txc_s & ~txc_q;
	assign rxc_fall = ~rxc_s & rxc_q;
	////////////////////////////////////////////////////////////////////////
	// Control register
	logic [2:0] ctrl_q, ctrl_d;
	logic wr_ctrl, wr_txd, rd_rxd;
	assign wr_ctrl = i_wr && (i_addr == mci_pkg::OFF_CTRL);
	assign wr_txd = i_wr && (i_addr == mci_pkg::OFF_TXD);
	assign rd_rxd = i_rd && (i_addr == mci_pkg::OFF_RXD);
	always_comb
	begin
		ctrl_d = ctrl_q;
		if (wr_ctrl)
			ctrl_d = i_wdata[2:0];
	end
	always_ff @(posedge i_mclk or negedge i_rstn)
	begin
		if (!i_rstn)
			ctrl_q <= mci_pkg::CTRL_RESET;
		else
			ctrl_q <= ctrl_d;
	end
	assign o_send_request = ctrl_q[mci_pkg::CTRL_SEND_REQ];
	assign o_terminal_ready = ctrl_q[mci_pkg::CTRL_TERM_RDY];
	assign o_secondary_send_request = ctrl_q[mci_pkg::CTRL_SEC_REQ];
	assign o_new_sync = 1'b0;
	////////////////////////////////////////////////////////////////////////
	// Transmitter
	mci_pkg::mci_tx_e tx_st_q, tx_st_d;
	logic [CHAR_W-1:0] tx_hold_q, tx_hold_d, tx_sh_q, tx_sh_d;
	logic tx_full_q, tx_full_d, txd_q, txd_d;
	logic [CW-1:0] tx_cnt_q, tx_cnt_d;
	logic tx_go;
	assign tx_go = o_send_request & clr_v & dsr_s & o_terminal_ready;
	always_comb
	begin
		tx_st_d = tx_st_q;
		tx_hold_d = tx_hold_q;
		tx_sh_d = tx_sh_q;
		tx_full_d = tx_full_q;
		txd_d = txd_q;
		tx_cnt_d = tx_cnt_q;
		if (wr_txd && !tx_full_q)
		begin
			tx_hold_d = i_wdata[CHAR_W-1:0];
			tx_full_d = 1'b1;
		end
		if (txc_rise)
		begin
			unique case (tx_st_q)
				mci_pkg::TX_IDLE:
				begin
					txd_d = 1'b1;
					if (tx_full_q && tx_go)
					begin
						tx_sh_d = tx_hold_q;
						tx_full_d = 1'b0;
						tx_st_d = mci_pkg::TX_START;
						txd_d = 1'b0;
					end
				end
				mci_pkg::TX_START,
				mci_pkg::TX_DATA:
				begin
					if (tx_st_q == mci_pkg::TX_START)
						tx_cnt_d = '0;
					else
						tx_cnt_d = tx_cnt_q + 1'b1;
					txd_d = tx_sh_q[0];
					tx_sh_d = {1'b1, tx_sh_q[CHAR_W-1:1]};
					if (tx_st_q == mci_pkg::TX_DATA
						&& tx_cnt_q == CW'(CHAR_W - 1))
					begin
						txd_d = 1'b1;
						tx_st_d = mci_pkg::TX_STOP;
					end
					else
						tx_st_d = mci_pkg::TX_DATA;
				end
				mci_pkg::TX_STOP:
				begin
					txd_d = 1'b1;
					tx_st_d = mci_pkg::TX_IDLE;
				end
			endcase
		end
	end
	always_ff @(posedge i_mclk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			tx_st_q <= mci_pkg::TX_IDLE;
			tx_hold_q <= '0;
			tx_sh_q <= '1;
			tx_full_q <= 1'b0;
			txd_q <= 1'b1;
			tx_cnt_q <= '0;
		end
		else
		begin
			tx_st_q <= tx_st_d;
			tx_hold_q <= tx_hold_d;
			tx_sh_q <= tx_sh_d;
			tx_full_q <= tx_full_d;
			txd_q <= txd_d;
			tx_cnt_q <= tx_cnt_d;
		end
	end
	assign o_tx_data_line = txd_q;
	////////////////////////////////////////////////////////////////////////
	// Receiver
	mci_pkg::mci_rx_e rx_st_q, rx_st_d;
	logic [CHAR_W-1:0] rx_sh_q, rx_sh_d, rx_buf_q, rx_buf_d;
	logic [CW-1:0] rx_cnt_q, rx_cnt_d;
	logic rx_val_q, rx_val_d, rx_ovr_q, rx_ovr_d;
	always_comb
	begin
		rx_st_d = rx_st_q;
		rx_sh_d = rx_sh_q;
		rx_buf_d = rx_buf_q;
		rx_cnt_d = rx_cnt_q;
		rx_val_d = rx_val_q;
		rx_ovr_d = rx_ovr_q;
		if (rd_rxd)
		begin
			rx_val_d = 1'b0;
			rx_ovr_d = 1'b0;
		end
		if (!det_v)
			rx_st_d = mci_pkg::RX_IDLE;
		else if (rxc_fall)
		begin
			unique case (rx_st_q)
				mci_pkg::RX_IDLE:
				begin
					rx_cnt_d = '0;
					if (!rxd_s)
						rx_st_d = mci_pkg::RX_DATA;
				end
				mci_pkg::RX_DATA:
				begin
					rx_sh_d = {rxd_s, rx_sh_q[CHAR_W-1:1]};
					rx_cnt_d = rx_cnt_q + 1'b1;
					if (rx_cnt_q == CW'(CHAR_W - 1))
						rx_st_d = mci_pkg::RX_STOP;
				end
				mci_pkg::RX_STOP:
				begin
					rx_st_d = mci_pkg::RX_IDLE;
					// New data beats a same-cycle read
					if (rxd_s)
					begin
						rx_buf_d = rx_sh_q;
						rx_ovr_d = rx_val_q & ~rd_rxd;
						rx_val_d = 1'b1;
					end
				end
				default: rx_st_d = mci_pkg::RX_IDLE;
			endcase
		end
	end
	always_ff @(posedge i_mclk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			rx_st_q <= mci_pkg::RX_IDLE;
			rx_sh_q <= '0;
			rx_buf_q <= '0;
			rx_cnt_q <= '0;
			rx_val_q <= 1'b0;
			rx_ovr_q <= 1'b0;
		end
		else
		begin
			rx_st_q <= rx_st_d;
			rx_sh_q <= rx_sh_d;
			rx_buf_q <= rx_buf_d;
			rx_cnt_q <= rx_cnt_d;
			rx_val_q <= rx_val_d;
			rx_ovr_q <= rx_ovr_d;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Read port
	logic [31:0] rdata_q, rdata_d;
	logic [8:0] stat;
	always_comb
	begin
		stat = '0;
		stat[mci_pkg::ST_CLEAR] = clr_v;
		stat[mci_pkg::ST_SET_RDY] = dsr_s;
		stat[mci_pkg::ST_LINE_DET] = det_v;
		stat[mci_pkg::ST_SEC_TONE] = sec_v;
		stat[mci_pkg::ST_RING] = ring_s;
		stat[mci_pkg::ST_TX_BUSY] = (tx_st_q != mci_pkg::TX_IDLE);
		stat[mci_pkg::ST_TX_FULL] = tx_full_q;
		stat[mci_pkg::ST_RX_VALID] = rx_val_q;
		stat[mci_pkg::ST_RX_OVR] = rx_ovr_q;
	end
	always_comb
	begin
		rdata_d = '0;
		if (i_rd)
		begin
			unique case (i_addr)
				mci_pkg::OFF_CTRL: rdata_d = {29'h0, ctrl_q};
				mci_pkg::OFF_STAT: rdata_d = {23'h0, stat};
				mci_pkg::OFF_TXD: rdata_d = 32'(tx_hold_q);
				mci_pkg::OFF_RXD: rdata_d = 32'(rx_buf_q);
				default: rdata_d = '0;
			endcase
		end
	end
	always_ff @(posedge i_mclk or negedge i_rstn)
	begin
		if (!i_rstn)
			rdata_q <= '0;
		else
			rdata_q <= rdata_d;
	end
	assign o_rdata = rdata_q;
endmodule // mci_top
`default_nettype wire

// [bench/mci_modem.sv]
// Behavioural modem on the far side of the serial link
`timescale 1ns/1ps
`default_nettype none
module mci_modem (
	input wire logic i_req,
	input wire logic i_txd,
	output logic o_clr,
	output logic o_txc,
	output logic o_rxc,
	output logic o_rxd,
	output logic o_det
);
	logic det_q = 1'b0;
	logic rxd_q = 1'b1;
	logic [9:0] sh_q = '0;
	logic [9:0] frame_q = '0;
	int bits = 0;
	int frames = 0;
	initial
	begin
		o_clr = 1'b0;
		o_txc = 1'b0;
		o_rxc = 1'b0;
	end
	// no soft turn-off tone: transmitter stops with request
	always @(i_req) o_clr <= #100 i_req;
	// Synchronous modem: transmit timing runs free
	always #24 o_txc = ~o_txc;
	assign o_det = det_q & ~i_req;
	assign o_rxd = o_det ? rxd_q : 1'b1;
	always @(negedge o_txc)
		if (bits > 0 || i_txd == 1'b0)
		begin
			sh_q = {i_txd, sh_q[9:1]};
			bits = (bits == 9) ? 0 : bits + 1;
			if (bits == 0)
			begin
				frame_q = sh_q;
				frames++;
			end
		end
	// data moves on rising receive timing
	task automatic send_char(input logic [7:0] c);
		logic [9:0] f;
		f = {1'b1, c, 1'b0};
		for (int i = 0; i < 11; i++)
		begin
			#24 o_rxc = 1'b1;
			rxd_q = (i < 10) ? f[i] : 1'b1;
			#24 o_rxc = 1'b0;
		end
	endtask
endmodule // mci_modem
`default_nettype wire

// [bench/mci_top_asserts.sv]
// Port checks for the modem control interface
`timescale 1ns/1ps
`default_nettype none
module mci_top_asserts #(
	parameter int CHAR_W = 8
) (
	input wire logic i_mclk,
	input wire logic i_rstn,
	input wire logic [3:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [31:0] o_rdata,
	input wire logic o_tx_data_line,
	input wire logic o_send_request,
	input wire logic i_set_ready,
	input wire logic o_terminal_ready,
	input wire logic o_secondary_send_request,
	input wire logic o_new_sync,
	input wire logic i_modem_tx_element_timing
);
	// Longer than any run of mark inside one frame
	localparam int IDLE_LIM = (CHAR_W + 2) * 10;
	logic [7:0] idle_q;
	logic [7:0] idle_d;
	logic ctrl_wr;
	assign ctrl_wr = i_wr && i_addr == mci_pkg::OFF_CTRL;
	always_comb
	begin
		idle_d = idle_q;
		if (!o_tx_data_line)
			idle_d = '0;
		else if (idle_q != 8'hff)
			idle_d = idle_q + 8'h01;
	end
	always_ff @(posedge i_mclk or negedge i_rstn)
		if (!i_rstn)
			idle_q <= '0;
		else
			idle_q <= idle_d;
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rstn);
	nsync_off_a: assert property (!o_new_sync)
		else $error("new sync raised");
	idle_mark_a: assert property (idle_q >= IDLE_LIM && !o_send_request
		&& !$past(o_send_request, 4) |=> o_tx_data_line)
		else $error("idle line left mark");
	tx_edge_a: assert property ($changed(o_tx_data_line) |->
		$past(i_modem_tx_element_timing) && !$past(i_modem_tx_element_timing, 6))
		else $error("tx data off timing edge");
	rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == '0)
		else $error("read data outside slot");
	stat_gate_a: assert property (i_rd && i_addr == mci_pkg::OFF_STAT
		&& !i_set_ready && !$past(i_set_ready, 3) |=> o_rdata[3:2] == 2'h0
		&& !o_rdata[mci_pkg::ST_CLEAR])
		else $error("status seen without ready");
	req_wr_a: assert property (ctrl_wr |=> o_send_request == $past(i_wdata[0]))
		else $error("send request wrong");
	sec_wr_a: assert property (ctrl_wr |=>
		o_secondary_send_request == $past(i_wdata[2]))
		else $error("secondary request wrong");
	ctrl_hold_a: assert property (!ctrl_wr |=> $stable(o_send_request)
		&& $stable(o_terminal_ready) && $stable(o_secondary_send_request))
		else $error("control moved unasked");
endmodule // mci_top_asserts
bind mci_top mci_top_asserts #(.CHAR_W(CHAR_W)) chk_u (.*);
`default_nettype wire

// [bench/mci_top_test.sv]
// Self-checking bench for the modem control interface
`timescale 1ns/1ps
`default_nettype none
module mci_top_test;
	logic i_mclk, i_rstn, i_wr, i_rd, i_ring, i_set_ready;
	logic [3:0] i_addr;
	logic [31:0] i_wdata, o_rdata, r;
	logic o_tx_data_line, i_rx_data_line, o_send_request, i_send_clear;
	logic o_terminal_ready, i_line_signal_detect, o_secondary_send_request;
	logic i_secondary_tone_detect, o_new_sync;
	logic i_modem_tx_element_timing, i_modem_rx_element_timing;
	int failures = 0;
	int checked = 0;
	mci_top dut_u (.*);
	mci_modem mdm_u (.i_req(o_send_request), .i_txd(o_tx_data_line),
		.o_clr(i_send_clear), .o_txc(i_modem_tx_element_timing),
		.o_rxc(i_modem_rx_element_timing), .o_rxd(i_rx_data_line),
		.o_det(i_line_signal_detect));
	initial
	begin
		i_mclk = 1'b0;
		forever #2.5 i_mclk = ~i_mclk;
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		checked++;
		if (s !== e)
		begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge i_mclk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_mclk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge i_mclk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_mclk);
		i_rd <= 1'b0;
		#1 r = o_rdata;
	endtask
	// Slow enough for the modem's clear to settle
	task automatic pins(input logic s, input logic g, input logic t);
		@(posedge i_mclk);
		i_set_ready <= s;
		i_ring <= g;
		i_secondary_tone_detect <= t;
		repeat (30) @(posedge i_mclk);
	endtask
	task automatic print_verdict;
		if (failures == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic t_reset;
		chk("txd", 32'h1, 32'(o_tx_data_line));
		chk("nsync", 32'h0, 32'(o_new_sync));
		rd(mci_pkg::OFF_CTRL);
		chk("ctrl", 32'h0, 32'(r[2:0]));
		rd(4'h2);
		chk("unmapped", 32'h0, r);
	endtask
	task automatic t_ctrl;
		for (int i = 0; i < 8; i++)
		begin
			wr(mci_pkg::OFF_CTRL, 32'(i));
			rd(mci_pkg::OFF_CTRL);
			chk("pins", 32'(i), {29'h0, o_secondary_send_request,
				o_terminal_ready, o_send_request});
			chk("ctrl_rd", 32'(i), 32'(r[2:0]));
		end
	endtask
	task automatic t_status;
		wr(mci_pkg::OFF_CTRL, 32'h0);
		pins(1'b0, 1'b1, 1'b1);
		rd(mci_pkg::OFF_STAT);
		chk("stat_off", 32'h10, 32'(r[4:0]));
		pins(1'b1, 1'b0, 1'b1);
		rd(mci_pkg::OFF_STAT);
		chk("stat_on", 32'ha, 32'(r[4:0]));
	endtask
	task automatic t_tx;
		logic ok;
		ok = 1'b1;
		pins(1'b0, 1'b0, 1'b0);
		wr(mci_pkg::OFF_CTRL, 32'h3);
		wr(mci_pkg::OFF_TXD, 32'hc3);
		repeat (400)
		begin
			@(posedge i_mclk);
			ok &= o_tx_data_line;
		end
		chk("held", 32'h1, 32'(ok));
		pins(1'b1, 1'b0, 1'b0);
		for (int i = 0; i < 3000 && mdm_u.frames == 0; i++)
			@(posedge i_mclk);
		chk("frame", 32'h386, 32'(mdm_u.frame_q));
		chk("after", 32'h1, 32'(o_tx_data_line));
		wr(mci_pkg::OFF_CTRL, 32'h2);
	endtask
	task automatic t_rx;
		mdm_u.det_q = 1'b1;
		mdm_u.send_char(8'h5a);
		rd(mci_pkg::OFF_STAT);
		chk("rx_valid", 32'h1, 32'(r[mci_pkg::ST_RX_VALID]));
		rd(mci_pkg::OFF_RXD);
		chk("rx_char", 32'h5a, 32'(r[7:0]));
		mdm_u.det_q = 1'b0;
		mdm_u.send_char(8'h00);
		rd(mci_pkg::OFF_STAT);
		chk("rx_quiet", 32'h0, 32'(r[mci_pkg::ST_RX_VALID]));
	endtask
	initial
	begin
		i_rstn = 1'b0;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_addr = '0;
		i_wdata = '0;
		i_set_ready = 1'b0;
		i_ring = 1'b0;
		i_secondary_tone_detect = 1'b0;
		repeat (4) @(posedge i_mclk);
		i_rstn <= 1'b1;
		t_reset();
		t_ctrl();
		t_status();
		t_tx();
		t_rx();
		print_verdict();
	end
	initial
	begin
		#60000;
		failures++;
		print_verdict();
	end
endmodule // mci_top_test
`default_nettype wire
